// >>> ss_supervisor.sv
// Starter supervision logic with AXI4-Lite register access
// Overview of operation
// - Analog output adds offset to scaled request
// - Analog output clamped at one hundred percent
// - Delay off: no line alarms, start faults
// - Delay set: no alarm, fault after delay
// - Feedback mismatch for set time: fault 48
// - Bypass mismatch raises no alarm stage
// - Feedback from dedicated or programmable input
// - Stop disabled ignored unless keypad controls
// - Stop enabled stops from any source
// - Auto start off: rising edge only
// - Power option starts on held input
// - Fault option starts on fault reset
// - Lockout clear acts as fault reset
// - Module address off or 16 to 23
// - Channels grouped off, stator, bearing, other
// - Channels 1-8 module one, 9-16 two
// - Group alarm when channel reaches level
// - Group trip after one second persistence
// - Voting needs two channels over trip
// - Single channel group disables voting
`timescale 1ns/100ps
`default_nettype none
`include "ss_params.svh"
module ss_supervisor #(
    parameter int P_TICK_CYC = `SS_TICK_MS * 1000_000 / `SS_CLK_NS,
    parameter int P_POLL_TK  = `SS_POLL_TK
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        i_line_present,
    input  wire logic        i_start_in,
    input  wire logic        i_keypad_stop,
    input  wire logic        i_bypass_fb,
    input  wire logic [7:0]  i_prog_inputs,
    input  wire logic        i_keypad_is_source,
    input  wire logic        i_up_to_speed_relay,
    input  wire logic [7:0]  i_aout_req,
    input  wire logic        i_rd_valid,
    input  wire logic [2:0]  i_rd_chan,
    input  wire logic [7:0]  i_rd_temp,
    input  wire logic        i_rd_done,
    output logic             o_poll_req,
    output logic [4:0]       o_poll_addr,
    output logic             o_run,
    output logic             o_ready,
    output logic             o_fault,
    output logic [7:0]       o_fault_code,
    output logic             o_noline_alarm,
    output logic [2:0]       o_temp_alarm,
    output logic [6:0]       o_aout
);
    localparam int TRIP_TK = `SS_TRIP_MS / `SS_TICK_MS;
    if (P_TICK_CYC < 1 || P_POLL_TK < 1 || P_POLL_TK > 255
        || TRIP_TK > 15) begin : g_chk
        $error("ss_supervisor: bad timing parameters");
    end

    // Software settings
    logic [31:0] r_ctrl, r_aout, r_time, r_mod, r_grp, r_alm, r_trp;
    logic        dly_off;            // Line contactor delay set Off
    logic        ks_en;              // Keypad stop enabled
    logic [1:0]  auto_mode;          // Bit0 power, bit1 fault
    logic        vote_en;            // Trip voting enable
    logic        fb_prog;            // Feedback from programmable input
    logic [2:0]  fb_idx;             // Which programmable input
    assign dly_off   = r_ctrl[0];
    assign ks_en     = r_ctrl[1];
    assign auto_mode = r_ctrl[3:2];
    assign vote_en   = r_ctrl[4];
    assign fb_prog   = r_ctrl[5];
    assign fb_idx    = r_ctrl[8:6];

    // Bus handshake state
    logic        aw_got, w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_wr;
    logic        wr_hit;
    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr = aw_got && w_got && !s_axi_bvalid;

    // Byte lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
        end
        return r;
    endfunction : merge

    // Capture write address and data in either order
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_got <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_wr) begin
                w_got <= 1'b0;
            end
        end
    end

    // Address decode of writable offsets
    always_comb begin
        case (aw_addr)
            `SS_A_CTRL, `SS_A_AOUT, `SS_A_TIME, `SS_A_MOD,
            `SS_A_GRP, `SS_A_ALM, `SS_A_TRP, `SS_A_CMD: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write response; unmapped gets slave error
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? 2'b00 : `SS_RSP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Setting registers
    logic fault_rst;                 // Fault reset or lockout clear
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            r_ctrl <= `SS_R_CTRL;
            r_aout <= `SS_R_AOUT;
            r_time <= `SS_R_TIME;
            r_mod  <= `SS_R_MOD;
            r_grp  <= `SS_R_GRP;
            r_alm  <= `SS_R_LVL;
            r_trp  <= `SS_R_LVL;
        end else if (do_wr) begin
            case (aw_addr)
                `SS_A_CTRL: r_ctrl <= merge(r_ctrl, w_data, w_strb);
                `SS_A_AOUT: r_aout <= merge(r_aout, w_data, w_strb);
                `SS_A_TIME: r_time <= merge(r_time, w_data, w_strb);
                `SS_A_MOD:  r_mod  <= merge(r_mod, w_data, w_strb);
                `SS_A_GRP:  r_grp  <= merge(r_grp, w_data, w_strb);
                `SS_A_ALM:  r_alm  <= merge(r_alm, w_data, w_strb);
                `SS_A_TRP:  r_trp  <= merge(r_trp, w_data, w_strb);
                default: ;
            endcase
        end
    end
    // Either command bit resets faults the same way
    assign fault_rst = do_wr && aw_addr == `SS_A_CMD && w_strb[0]
                       && (w_data[0] || w_data[1]);

    // Pin synchronisers; stage one read only by stage two
    logic [11:0] sy1, sy2;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sy1 <= 12'h000;
            sy2 <= 12'h000;
        end else begin
            sy1 <= {i_prog_inputs, i_bypass_fb, i_keypad_stop,
                    i_start_in, i_line_present};
            sy2 <= sy1;
        end
    end
    logic line_ok, start_s, kstop_s, fb_s;
    logic [7:0] prog_s;
    assign line_ok = sy2[0];
    assign start_s = sy2[1];
    assign kstop_s = sy2[2];
    assign fb_s    = sy2[3];
    assign prog_s  = sy2[11:4];

    // Tenth-second tick
    logic [$clog2(P_TICK_CYC+1)-1:0] tick_cnt;
    logic tick;
    assign tick = tick_cnt == '0;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || tick)
            tick_cnt <= ($clog2(P_TICK_CYC+1))'(P_TICK_CYC - 1);
        else
            tick_cnt <= tick_cnt - 1'b1;
    end

    // Analog output: offset plus scaled request, clamped
    logic [14:0] scaled;
    logic [8:0]  aout_sum;
    assign scaled   = 15'(i_aout_req * r_aout[14:8]) / `SS_DIV_PCT;
    assign aout_sum = 9'(scaled) + 9'(r_aout[6:0]);
    always_ff @(posedge i_clk_sys) begin
        if (i_reset)
            o_aout <= 7'h00;
        else if (aout_sum > 9'(`SS_FULL_PCT))
            o_aout <= `SS_FULL_PCT;
        else
            o_aout <= aout_sum[6:0];
    end

    // Start decision and keypad stop
    logic start_d, stop_eff, start_edge, auto_pwr, auto_flt;
    logic pwr_pend, temp_flt, byp_flt, nol_flt;
    logic [1:0] pwr_cnt;
    logic       ctrl_seen;           // Control word written since reset
    // Key honoured when enabled or keypad is control source
    assign stop_eff = kstop_s && (ks_en || i_keypad_is_source);
    // No edge while the synchronisers still fill after reset
    assign start_edge = start_s && !start_d
                        && pwr_cnt == 2'd3;
    // Settings come after power-up, so the look waits for them
    assign auto_pwr = pwr_pend && pwr_cnt == 2'd3 && ctrl_seen
                      && auto_mode[0] && start_s;
    assign auto_flt = fault_rst && auto_mode[1] && start_s;
    // Wait for synchronisers to fill before the power-up look
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            start_d   <= 1'b0;
            pwr_pend  <= 1'b1;
            pwr_cnt   <= 2'd0;
            ctrl_seen <= 1'b0;
        end else begin
            start_d <= start_s;
            if (do_wr && aw_addr == `SS_A_CTRL) ctrl_seen <= 1'b1;
            if (pwr_cnt != 2'd3) pwr_cnt <= pwr_cnt + 2'd1;
            else if (ctrl_seen) pwr_pend <= 1'b0;
        end
    end

    // Run state; a fault or an honoured stop ends it
    logic start_go;
    assign start_go = (start_edge || auto_pwr || auto_flt) && !stop_eff;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset)
            o_run <= 1'b0;
        // A fault being reset must not block its own auto start
        else if ((o_fault && !fault_rst) || stop_eff || temp_flt
                 || byp_flt || nol_flt)
            o_run <= 1'b0;
        else if (start_go && (line_ok || !dly_off))
            o_run <= 1'b1;
    end

    // Line presence: alarm only when no contactor expected
    logic [6:0] nol_cnt;
    assign o_noline_alarm = dly_off && !line_ok && !o_run;
    assign o_ready = !o_fault && (line_ok || !dly_off);
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || line_ok || !o_run)
            nol_cnt <= 7'd0;
        else if (tick && nol_cnt != 7'h7F)
            nol_cnt <= nol_cnt + 7'd1;
    end
    // Zero delay faults at once; Off faults on start
    assign nol_flt = !o_fault && (
        (dly_off && start_go && !line_ok) ||
        (!dly_off && o_run && !line_ok
         && nol_cnt >= r_time[6:0]));

    // Bypass feedback mismatch timer, no alarm stage
    logic fb_sel, mism;
    logic [5:0] byp_cnt;
    assign fb_sel = fb_prog ? prog_s[fb_idx] : fb_s;
    assign mism = fb_sel != i_up_to_speed_relay;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || !mism)
            byp_cnt <= 6'd0;
        else if (tick && byp_cnt != 6'h3F)
            byp_cnt <= byp_cnt + 6'd1;
    end
    assign byp_flt = !o_fault && mism
                     && byp_cnt >= r_time[13:8];

    // Temperature module polling
    ss_pkg::ss_poll_t pst;
    logic       pmod;                // Module being polled
    logic [7:0] temps [16];          // Latest channel readings
    logic       fresh;               // Both modules polled or skipped once since reset
    logic [7:0] poll_tk;
    logic [4:0] maddr;
    logic       mod_on;
    assign maddr  = pmod ? r_mod[12:8] : r_mod[4:0];
    // Only 16..23 count as a live address
    assign mod_on = maddr[4] && !maddr[3];
    assign o_poll_addr = maddr;
    assign o_poll_req  = pst == ss_pkg::SS_REQ && mod_on;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pst     <= ss_pkg::SS_IDLE;
            pmod    <= 1'b0;
            fresh   <= 1'b0;
            poll_tk <= 8'd0;
        end else begin
            if (tick && poll_tk != 8'hFF) poll_tk <= poll_tk + 8'd1;
            case (pst)
                ss_pkg::SS_IDLE: begin
                    if (poll_tk >= 8'(P_POLL_TK)) begin
                        poll_tk <= 8'd0;
                        pmod    <= 1'b0;
                        pst     <= ss_pkg::SS_REQ;
                    end
                end
                ss_pkg::SS_REQ: begin
                    // Off module skipped without a request
                    if (!mod_on && pmod) begin
                        fresh <= 1'b1;
                        pst   <= ss_pkg::SS_IDLE;
                    end else if (!mod_on) begin
                        pmod <= 1'b1;
                    end else begin
                        pst <= ss_pkg::SS_WAIT;
                    end
                end
                ss_pkg::SS_WAIT: begin
                    if (i_rd_done && pmod) begin
                        fresh <= 1'b1;
                        pst   <= ss_pkg::SS_IDLE;
                    end else if (i_rd_done) begin
                        pmod <= 1'b1;
                        pst  <= ss_pkg::SS_REQ;
                    end
                end
                default: pst <= ss_pkg::SS_IDLE;
            endcase
        end
    end
    // Readings land at module base plus channel
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            for (int c = 0; c < 16; c++) temps[c] <= 8'h00;
        end else if (pst == ss_pkg::SS_WAIT && i_rd_valid) begin
            temps[{pmod, i_rd_chan}] <= i_rd_temp;
        end
    end

    // Group evaluation; other channels vote as a group too
    logic [2:0] g_alm, g_trip;
    logic [4:0] g_cnt [3];
    logic [4:0] g_over [3];
    ss_pkg::ss_grp_t gi;
    logic       o_over;
    always_comb begin
        g_alm  = 3'b000;
        g_trip = 3'b000;
        o_over = 1'b0;
        gi     = ss_pkg::SS_G_OFF;
        for (int g = 0; g < 3; g++) begin
            g_cnt[g]  = 5'd0;
            g_over[g] = 5'd0;
        end
        for (int c = 0; c < 16; c++) begin
            gi = ss_pkg::ss_grp_t'(r_grp[2*c +: 2]);
            if (gi != ss_pkg::SS_G_OFF && fresh) begin
                g_cnt[gi-1] = g_cnt[gi-1] + 5'd1;
                if (temps[c] >= r_alm[8*(gi-1) +: 8])
                    g_alm[gi-1] = 1'b1;
                if (temps[c] > r_trp[8*(gi-1) +: 8]) begin
                    g_over[gi-1] = g_over[gi-1] + 5'd1;
                    if (gi == ss_pkg::SS_G_OTHER) o_over = 1'b1;
                end
            end
        end
        for (int g = 0; g < 2; g++) begin
            // Voting only when the group has two or more members
            if (vote_en && g_cnt[g] > 5'd1)
                g_trip[g] = g_over[g] >= 5'd2;
            else
                g_trip[g] = g_over[g] != 5'd0;
        end
        g_trip[2] = vote_en && g_cnt[2] > 5'd1 ?
                    g_over[2] >= 5'd2 : o_over;
    end
    assign o_temp_alarm = g_alm;

    // One-second persistence per group
    logic [3:0] tp_cnt [3];
    logic [2:0] tp_done;
    for (genvar g = 0; g < 3; g++) begin : g_persist
        always_ff @(posedge i_clk_sys) begin
            if (i_reset || !g_trip[g])
                tp_cnt[g] <= 4'd0;
            else if (tick && tp_cnt[g] != 4'(TRIP_TK))
                tp_cnt[g] <= tp_cnt[g] + 4'd1;
        end
        assign tp_done[g] = g_trip[g] && tp_cnt[g] == 4'(TRIP_TK);
    end
    assign temp_flt = !o_fault && |tp_done;

    // Fault latch; first cause kept until reset
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_fault      <= 1'b0;
            o_fault_code <= 8'h00;
        end else if (nol_flt) begin
            o_fault      <= 1'b1;
            o_fault_code <= `SS_FC_NOLINE;
        end else if (byp_flt) begin
            o_fault      <= 1'b1;
            o_fault_code <= `SS_FC_BYPASS;
        end else if (temp_flt) begin
            o_fault      <= 1'b1;
            o_fault_code <= `SS_FC_TEMP;
        end else if (fault_rst) begin
            o_fault      <= 1'b0;
            o_fault_code <= 8'h00;
        end
    end

    // Read channel; status shows live block state
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
                `SS_A_CTRL: s_axi_rdata <= r_ctrl;
                `SS_A_AOUT: s_axi_rdata <= r_aout;
                `SS_A_TIME: s_axi_rdata <= r_time;
                `SS_A_MOD:  s_axi_rdata <= r_mod;
                `SS_A_GRP:  s_axi_rdata <= r_grp;
                `SS_A_ALM:  s_axi_rdata <= r_alm;
                `SS_A_TRP:  s_axi_rdata <= r_trp;
                `SS_A_STAT: s_axi_rdata <= {16'h0000, o_fault_code,
                    fresh, o_temp_alarm, o_noline_alarm, o_fault,
                    o_ready, o_run};
                `SS_A_AVAL: s_axi_rdata <= {25'h000_0000, o_aout};
                `SS_A_CMD:  s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `SS_RSP_ERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_aout_clamp: assert property (o_aout <= `SS_FULL_PCT)
        else $error("analog output above full scale");
    a_aout_zero: assert property (i_aout_req == 8'h00 &&
        r_aout[6:0] <= 7'd99 |=> o_aout == $past(r_aout[6:0]))
        else $error("zero request not equal to offset");
    a_noline_alarm: assert property (dly_off && !line_ok
        && !o_run |-> o_noline_alarm && !o_ready)
        else $error("no line alarm or ready wrong");
    a_noline_delay: assert property (!dly_off |->
        !o_noline_alarm && (o_ready || o_fault))
        else $error("alarm with line delay set");
    a_bypass_code: assert property (byp_flt && !nol_flt
        |=> o_fault && o_fault_code == `SS_FC_BYPASS)
        else $error("bypass fault code wrong");
    a_bypass_early: assert property ($rose(mism)
        && r_time[13:8] != 6'd0 |-> !byp_flt)
        else $error("bypass fault without elapsed time");
    a_kstop_ign: assert property (kstop_s && !ks_en
        && !i_keypad_is_source && o_run && !o_fault
        && !nol_flt && !byp_flt && !temp_flt |=> o_run)
        else $error("disabled keypad stop acted");
    a_kstop_act: assert property (kstop_s && ks_en
        |=> !o_run)
        else $error("keypad stop did not stop");
    a_start_edge: assert property ($rose(o_run) |->
        $past(start_edge || auto_pwr || auto_flt))
        else $error("start without edge or auto case");
    a_trip_hold: assert property ($rose(g_trip[0])
        ##1 g_trip[0][*2] |-> !tp_done[0])
        else $error("trip before persistence");
    c_run: cover property ($rose(o_run));
    c_bypass: cover property (byp_flt);
    c_temp: cover property (temp_flt);
    c_poll: cover property (pst == ss_pkg::SS_WAIT && i_rd_done);
endmodule : ss_supervisor
`default_nettype wire

// >>> ss_params.svh
// Constants for the starter supervision block
`ifndef SS_PARAMS_SVH
`define SS_PARAMS_SVH
// Register byte offsets
`define SS_A_CTRL    8'h00
`define SS_A_AOUT    8'h04
`define SS_A_TIME    8'h08
`define SS_A_MOD     8'h0C
`define SS_A_GRP     8'h10
`define SS_A_ALM     8'h14
`define SS_A_TRP     8'h18
`define SS_A_STAT    8'h1C
`define SS_A_AVAL    8'h20
`define SS_A_CMD     8'h24
// Reset values
`define SS_R_CTRL    32'h0000_0002
`define SS_R_AOUT    32'h0000_6400
`define SS_R_TIME    32'h0000_141E
`define SS_R_MOD     32'h0000_0000
`define SS_R_GRP     32'h0000_0000
`define SS_R_LVL     32'h00C8_C8C8
// Percent limits
`define SS_FULL_PCT  7'd100
`define SS_DIV_PCT   15'd100
// Fault codes
`define SS_FC_NOLINE 8'h01
`define SS_FC_BYPASS 8'd48
`define SS_FC_TEMP   8'h02
// Timing: clock period, tick, trip delay, poll interval; bus error response
`define SS_CLK_NS    100
`define SS_TICK_MS   100
`define SS_TRIP_MS   1000
`define SS_POLL_TK   5
`define SS_RSP_ERR   2'b10
`endif

// >>> ss_pkg.sv
// Types shared by the starter supervision block
`default_nettype none
package ss_pkg;
    // Temperature module poll sequencer
    typedef enum logic [1:0] {
        SS_IDLE,
        SS_REQ,
        SS_WAIT
    } ss_poll_t;
    // Channel group assignment
    typedef enum logic [1:0] {
        SS_G_OFF,
        SS_G_STATOR,
        SS_G_BEARING,
        SS_G_OTHER
    } ss_grp_t;
endpackage : ss_pkg
`default_nettype wire

// >>> ss_temp_model.sv
// Behavioural remote temperature module answering polls
`timescale 1ns/100ps
`default_nettype none
module ss_temp_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_poll_req,
    input  wire logic [4:0] i_poll_addr,
    input  wire logic [7:0] i_hot,
    output logic            o_rd_valid,
    output logic [2:0]      o_rd_chan,
    output logic [7:0]      o_rd_temp,
    output logic            o_rd_done
);
    // Readings still owed for the current poll
    int left = 0;
    initial {o_rd_valid, o_rd_chan, o_rd_temp, o_rd_done} = '0;
    // Channel 0 is hot; idle data toggles so stale values never match
    always @(posedge i_clk_sys) begin
        o_rd_valid <= left > 1;
        o_rd_done  <= left == 1;
        o_rd_chan  <= 3'(9 - left);
        o_rd_temp  <= left > 1 ? (left == 9 ? i_hot : 8'h19) : ~o_rd_temp;
        if (i_poll_req && i_poll_addr inside {[16:23]}) begin
            left <= 9;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
endmodule : ss_temp_model
`default_nettype wire

// >>> starter_supervision_logic_tb.sv
// Self-checking bench for the starter supervision block
`timescale 1ns/100ps
`default_nettype none
`include "ss_params.svh"
module starter_supervision_logic_tb;
    typedef struct packed {
        logic [31:0] cfg;
        logic [7:0]  req;
        logic [6:0]  exp;
    } ss_row_t;
    logic i_clk_sys = 0, i_reset = 1, i_line_present = 1, i_start_in = 0;
    logic i_keypad_stop = 0, i_bypass_fb = 0, i_keypad_is_source = 0;
    logic i_up_to_speed_relay = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, i_prog_inputs = '0;
    logic [7:0] i_aout_req = '0, hot = '0, i_rd_temp, o_fault_code;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, i_rd_valid, i_rd_done, o_poll_req, o_run, o_ready;
    logic o_fault, o_noline_alarm;
    logic [1:0] s_axi_bresp, s_axi_rresp, rp;
    logic [2:0] i_rd_chan, o_temp_alarm;
    logic [4:0] o_poll_addr;
    logic [6:0] o_aout;
    int miscompares = 0, check_count = 0;
    // Analog cases: config word, request, expected output
    ss_row_t rows[6] = '{{32'h0000_6400, 8'd40, 7'd40},
        {32'h0000_3232, 8'd0, 7'd50}, {32'h0000_3232, 8'd100, 7'd100},
        {32'h0000_3232, 8'd60, 7'd80}, {32'h0000_6414, 8'd100, 7'd100},
        {32'h0000_7D00, 8'd100, 7'd100}};
    always #50 i_clk_sys = ~i_clk_sys;
    // Tick shortened to 10 cycles
    ss_supervisor #(.P_TICK_CYC(10), .P_POLL_TK(5)) DUT (.i_clk_sys,
        .i_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .i_line_present, .i_start_in,
        .i_keypad_stop, .i_bypass_fb, .i_prog_inputs, .i_keypad_is_source,
        .i_up_to_speed_relay, .i_aout_req, .i_rd_valid, .i_rd_chan,
        .i_rd_temp, .i_rd_done, .o_poll_req, .o_poll_addr, .o_run,
        .o_ready, .o_fault, .o_fault_code, .o_noline_alarm, .o_temp_alarm,
        .o_aout);
    ss_temp_model PART (.i_clk_sys, .i_poll_req(o_poll_req),
        .i_poll_addr(o_poll_addr), .i_hot(hot), .o_rd_valid(i_rd_valid),
        .o_rd_chan(i_rd_chan), .o_rd_temp(i_rd_temp), .o_rd_done(i_rd_done));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cyc
    // One transfer; ready seen before the edge, released after it
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        logic ta, tw, tr, rs;
        int n;
        n = 0;
        @(posedge i_clk_sys);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(negedge i_clk_sys);
            {ta, tw, tr} = {s_axi_awready, s_axi_wready, s_axi_arready};
            rs = w ? s_axi_bvalid : s_axi_rvalid;
            {q, rp} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
            @(posedge i_clk_sys);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tr) s_axi_arvalid <= 0;
        end while (!rs && ++n < 50);
        {s_axi_bready, s_axi_rready} <= 2'b00;
        chk("bus answer", 1, rs);
    endtask : bus
    task automatic rd(logic [7:0] a, logic [31:0] e);
        bus(0, a, 0);
        chk("read data", e, q);
    endtask : rd
    task automatic final_report();
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    // Watchdog: whole run needs under 2000 cycles
    initial begin
        #1_000_000;
        miscompares++;
        final_report();
    end
    initial begin
        cyc(20);
        i_reset <= 0;
        rd(`SS_A_CTRL, `SS_R_CTRL);
        rd(`SS_A_TIME, `SS_R_TIME);
        rd(`SS_A_TRP, `SS_R_LVL);
        bus(0, 8'h28, 0);
        chk("unmapped resp", `SS_RSP_ERR, rp);
        foreach (rows[i]) begin
            bus(1, `SS_A_AOUT, rows[i].cfg);
            i_aout_req <= rows[i].req;
            cyc(4);
            chk("aout", rows[i].exp, o_aout);
        end
        bus(1, `SS_A_CTRL, 32'h0000_0003);
        i_line_present <= 0;
        cyc(8);
        chk("noline alarm", 2'b10, {o_noline_alarm, o_ready});
        i_start_in <= 1;
        cyc(8);
        chk("noline fault", {1'b0, `SS_FC_NOLINE}, {o_run, o_fault_code});
        i_line_present <= 1;
        bus(1, `SS_A_CTRL, 32'h0000_000B);
        bus(1, `SS_A_CMD, 32'h0000_0001);
        cyc(8);
        chk("auto run", 1, o_run);
        i_keypad_stop <= 1;
        cyc(8);
        chk("stop enabled", 0, o_run);
        i_keypad_stop <= 0;
        cyc(8);
        chk("held start", 0, o_run);
        bus(1, `SS_A_CTRL, 32'h0000_01F1);
        i_start_in <= 0;
        cyc(4);
        i_start_in <= 1;
        i_keypad_stop <= 1;
        cyc(8);
        chk("stop ignored", 1, o_run);
        i_keypad_is_source <= 1;
        cyc(8);
        chk("keypad source", 0, o_run);
        i_up_to_speed_relay <= 1;
        i_bypass_fb <= 1;
        cyc(150);
        chk("no early alarm", 0, {o_fault, o_noline_alarm});
        cyc(100);
        chk("bypass fault", `SS_FC_BYPASS, o_fault_code);
        i_up_to_speed_relay <= 0;
        i_bypass_fb <= 0;
        bus(1, `SS_A_CMD, 32'h0000_0002);
        hot <= 8'd150;
        bus(1, `SS_A_ALM, 32'h00C8_C864);
        bus(1, `SS_A_TRP, 32'h00C8_C864);
        bus(1, `SS_A_GRP, 32'h0000_0001);
        bus(1, `SS_A_MOD, 32'h0000_1F10);
        cyc(120);
        chk("stator alarm", 3'b001, o_temp_alarm);
        cyc(200);
        chk("temp trip", `SS_FC_TEMP, o_fault_code);
        i_keypad_stop <= 0;
        i_reset <= 1;
        cyc(2);
        i_reset <= 0;
        cyc(6);
        chk("held start after reset", 0, o_run);
        bus(1, `SS_A_CTRL, 32'h0000_0006);
        cyc(4);
        chk("power start", 1, o_run);
        final_report();
    end
endmodule : starter_supervision_logic_tb
`default_nettype wire
